/* File: verilog/pmi_pkg.sv */
// package: register map, field layout, modes and timing for the integration controller
package pmi_pkg;
  // register map
  localparam logic [7:0] ctrl_offset = 8'h02;
  localparam logic [7:0] ctrl_reset = 8'h00;
  // control register field positions
  localparam int fsr_lsb = 6;
  localparam int sel_lsb = 4;
  localparam int sample_count_sel_lsb = 0;
  // widths
  localparam int dac_w = 10;
  localparam int samp_w = 16;
  localparam int acc_w = 44;
  localparam int cnt_w = 12;
  localparam logic [cnt_w-1:0] max_samples = 12'h800;
  localparam logic [3:0] sample_count_sel_max_code = 4'hb;
  // output select modes
  typedef enum logic [1:0] {
    pmi_pwr_pin = 2'h0,
    pmi_sns_free = 2'h1,
    pmi_bus_free = 2'h2,
    pmi_pwr_free = 2'h3
  } pmi_sel_t;
  // timing, 200 MHz clock
  localparam int clk_mhz = 200;
  localparam int update_hold_us = 1000;
  localparam int update_hold_cyc = update_hold_us * clk_mhz;
endpackage

/* File: verilog/pmi_divider.sv */
// sequential restoring divider for the averaging step
`timescale 1ns/100ps
`default_nettype none
module pmi_divider #(
  parameter int num_w = 44,
  parameter int den_w = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request
  input wire logic start,
  input wire logic [num_w-1:0] numer,
  input wire logic [den_w-1:0] denom,
  // answer
  output logic busy,
  output logic done,
  output logic [num_w-1:0] quot
);
  logic [num_w-1:0] q_reg; // shifting numerator becomes quotient
  logic [den_w:0] rem_reg; // partial remainder
  logic [den_w-1:0] d_reg; // latched divisor
  logic [6:0] cnt_reg; // bits left
  logic [den_w:0] trial; // remainder shifted with next bit
  assign trial = {rem_reg[den_w-1:0], q_reg[num_w-1]};
  assign quot = q_reg;
  // one quotient bit per cycle; any divisor, not only powers of two
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q_reg <= '0;
      rem_reg <= '0;
      d_reg <= '0;
      cnt_reg <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        q_reg <= numer;
        rem_reg <= '0;
        d_reg <= (denom == '0) ? {{(den_w-1){1'b0}}, 1'b1} : denom; // zero divisor guard
        cnt_reg <= 7'(num_w);
        busy <= 1'b1;
      end else if (busy) begin
        if (trial >= {1'b0, d_reg}) begin
          rem_reg <= trial - {1'b0, d_reg};
          q_reg <= {q_reg[num_w-2:0], 1'b1};
        end else begin
          rem_reg <= trial;
          q_reg <= {q_reg[num_w-2:0], 1'b0};
        end
        cnt_reg <= cnt_reg - 7'h01;
        if (cnt_reg == 7'h01) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: verilog/pmi_integ_ctrl.sv */
// measurement accumulation, averaging and output latch control for the power monitor
`timescale 1ns/100ps
`default_nettype none
module pmi_integ_ctrl #(
  parameter int update_hold = pmi_pkg::update_hold_cyc
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // host line and pin override
  input wire logic read_int_pin,
  input wire logic line_override,
  input wire logic int_enable,
  input wire logic sleep_req,
  // control register port
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  output logic [7:0] ctrl_rdata,
  // gains
  input wire logic [2:0] current_digital_gain,
  input wire logic [2:0] bus_digital_gain,
  // adc samples
  input wire logic sample_valid,
  input wire logic [pmi_pkg::samp_w-1:0] sample_data,
  output logic mux_selector,
  // results
  output logic [15:0] power_result,
  output logic [15:0] sense_result,
  output logic [15:0] bus_result,
  output logic [pmi_pkg::dac_w-1:0] dac_code,
  output logic [1:0] out_full_scale,
  output logic dac_update,
  output logic integrating
);
  typedef enum logic [1:0] {
    st_idle = 2'h0,
    st_integ = 2'h1,
    st_calc = 2'h3
  } pmi_state_t;
  localparam int hold_w = $clog2(update_hold + 1);
  pmi_state_t state_reg;
  logic [7:0] ctrl_reg; // control register
  logic pin_s1, pin_s2; // line synchroniser
  logic int_now, int_prev; // integrate state
  logic [pmi_pkg::acc_w-1:0] acc_reg; // selected sum accumulator
  logic [pmi_pkg::cnt_w-1:0] cnt_reg; // samples taken
  logic [pmi_pkg::samp_w-1:0] bus_hold_reg; // bus half of a power pair
  logic [hold_w-1:0] hold_reg; // low-time counter
  logic hold_done_reg; // hold update already taken
  pmi_pkg::pmi_sel_t mode_reg; // mode latched at period start
  logic [pmi_pkg::cnt_w-1:0] target; // free-run sample target
  logic div_start, div_done; // divider busy is not needed, calc state tracks it
  logic [pmi_pkg::acc_w-1:0] div_q;
  logic [20:0] gained; // quotient after digital gain
  logic [15:0] res16; // saturated 16-bit result
  logic hold_fire; // line low long enough
  logic period_full; // sample target reached
  assign out_full_scale = ctrl_reg[pmi_pkg::fsr_lsb +: 2];
  assign ctrl_rdata = ctrl_reg;
  assign integrating = (state_reg == st_integ);
  // control register write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_reg <= pmi_pkg::ctrl_reset;
    end else if (ctrl_wr) begin
      ctrl_reg <= ctrl_wdata;
    end
  end
  // two-flop sync of the host line
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      int_prev <= 1'b0;
    end else begin
      pin_s1 <= read_int_pin;
      pin_s2 <= pin_s1;
      int_prev <= int_now;
    end
  end
  assign int_now = line_override ? int_enable : pin_s2;
  // free-run target: 2^code, codes above eleven give 2048
  always_comb begin
    target = pmi_pkg::max_samples;
    if (ctrl_reg[pmi_pkg::sample_count_sel_lsb +: 4] <= pmi_pkg::sample_count_sel_max_code) begin
      target = pmi_pkg::cnt_w'(1) << ctrl_reg[pmi_pkg::sample_count_sel_lsb +: 4];
    end
  end
  assign period_full = (mode_reg == pmi_pkg::pmi_pwr_pin) ? (cnt_reg == pmi_pkg::max_samples)
                                                         : (cnt_reg == target);
  // low-hold counter; only meaningful while the line sits low in pin mode
  always_ff @(posedge clk) begin
    if (!rst_n || int_now) begin
      hold_reg <= '0;
      hold_done_reg <= 1'b0;
    end else if (hold_reg != hold_w'(update_hold)) begin
      hold_reg <= hold_reg + hold_w'(1);
    end else if (hold_fire) begin
      hold_done_reg <= 1'b1;
    end
  end
  assign hold_fire = (hold_reg == hold_w'(update_hold)) && !hold_done_reg
                     && (mode_reg == pmi_pkg::pmi_pwr_pin);
  assign div_start = (state_reg == st_integ) && (period_full ||
                     ((mode_reg == pmi_pkg::pmi_pwr_pin) && !int_now && int_prev));
  // main sequence: integrate, calculate, restart
  always_ff @(posedge clk) begin
    if (!rst_n || sleep_req) begin
      state_reg <= st_idle;
      acc_reg <= '0;
      cnt_reg <= '0;
      bus_hold_reg <= '0;
      mux_selector <= 1'b0;
      mode_reg <= pmi_pkg::pmi_pwr_pin;
    end else begin
      case (state_reg)
        st_idle: begin
          if (int_now) begin
            mode_reg <= pmi_pkg::pmi_sel_t'(ctrl_reg[pmi_pkg::sel_lsb +: 2]);
            acc_reg <= '0;
            cnt_reg <= '0;
            mux_selector <= (ctrl_reg[pmi_pkg::sel_lsb +: 2] == pmi_pkg::pmi_sns_free);
            state_reg <= st_integ;
          end
        end
        st_integ: begin
          if (div_start) begin
            state_reg <= st_calc;
          end else if (!int_now) begin
            state_reg <= st_idle;
          end else if (sample_valid) begin
            if (mode_reg == pmi_pkg::pmi_pwr_pin || mode_reg == pmi_pkg::pmi_pwr_free) begin
              mux_selector <= ~mux_selector;
              if (!mux_selector) begin
                bus_hold_reg <= sample_data;
              end else begin
                // widen both factors first, a bare product would keep only sixteen bits
                acc_reg <= acc_reg + (pmi_pkg::acc_w'(bus_hold_reg) * pmi_pkg::acc_w'(sample_data));
                cnt_reg <= cnt_reg + pmi_pkg::cnt_w'(1);
              end
            end else begin
              acc_reg <= acc_reg + pmi_pkg::acc_w'(sample_data);
              cnt_reg <= cnt_reg + pmi_pkg::cnt_w'(1);
            end
          end
        end
        st_calc: begin
          if (div_done) begin
            acc_reg <= '0;
            cnt_reg <= '0;
            state_reg <= int_now ? st_integ : st_idle;
          end
        end
        default: state_reg <= st_idle;
      endcase
    end
  end
  // gain stage: power uses the current gain only, single channels their own
  always_comb begin
    gained = 21'(div_q[15:0]);
    case (mode_reg)
      pmi_pkg::pmi_sns_free: gained = 21'(div_q[15:0]) << current_digital_gain;
      pmi_pkg::pmi_bus_free: gained = 21'(div_q[15:0]) << (bus_digital_gain > 3'h5 ? 3'h5 : bus_digital_gain);
      default: gained = 21'(div_q[31:16]) << current_digital_gain;
    endcase
    res16 = (gained[20:16] != 5'h00) ? 16'hffc0 : {gained[15:6], 6'h00};
  end
  // result registers and output latch
  always_ff @(posedge clk) begin
    if (!rst_n || sleep_req) begin
      power_result <= '0;
      sense_result <= '0;
      bus_result <= '0;
      dac_code <= '0;
      dac_update <= 1'b0;
    end else begin
      dac_update <= 1'b0;
      if (div_done) begin
        case (mode_reg)
          pmi_pkg::pmi_sns_free: sense_result <= res16;
          pmi_pkg::pmi_bus_free: bus_result <= res16;
          default: power_result <= res16;
        endcase
        dac_code <= res16[15:6];
        dac_update <= 1'b1;
      end else if (hold_fire) begin
        dac_code <= power_result[15:6];
        dac_update <= 1'b1;
      end
    end
  end
  // averaging divider, divides by the real count
  pmi_divider #(.num_w(pmi_pkg::acc_w), .den_w(pmi_pkg::cnt_w)) u_div (
    .clk(clk),
    .rst_n(rst_n && !sleep_req),
    .start(div_start),
    .numer(acc_reg),
    .denom(cnt_reg),
    .busy(),
    .done(div_done),
    .quot(div_q)
  );
endmodule
`default_nettype wire

/* File: bench/pmi_integ_ctrl_assertions.sv */
// assertion checker for the integration controller
`timescale 1ns/100ps
`default_nettype none
module pmi_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // host line and control
  input wire logic read_int_pin,
  input wire logic line_override,
  input wire logic int_enable,
  input wire logic sleep_req,
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  // outputs
  input wire logic [7:0] ctrl_rdata,
  input wire logic [15:0] power_result,
  input wire logic [pmi_pkg::dac_w-1:0] dac_code,
  input wire logic [1:0] out_full_scale,
  input wire logic dac_update,
  input wire logic integrating
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // level the state should follow
  wire logic want = line_override ? int_enable : read_int_pin;
  // pin-controlled power selected
  wire logic pin = ctrl_rdata[5:4] == 2'h0;
  a_range_field: assert property (
    out_full_scale == ctrl_rdata[7:6]) else $error("range field");
  a_ctrl_write: assert property (
    ctrl_wr |=> ctrl_rdata == $past(ctrl_wdata)) else $error("control write");
  a_update_pulse: assert property (
    dac_update |=> !dac_update) else $error("update pulse");
  a_result_frac: assert property (
    power_result[5:0] == 6'h0) else $error("result low bits");
  a_dac_power: assert property (
    dac_update && pin |=> dac_code == power_result[15:6]) else $error("dac code");
  a_sleep_clear: assert property (
    sleep_req |=> dac_code == 0 && power_result == 0) else $error("sleep clear");
  // a code change is only allowed with an update or a sleep clear
  a_dac_holds: assert property (
    $changed(dac_code) |-> dac_update || $past(dac_update) || $past(sleep_req)) else $error("dac moved");
  a_read_state: assert property (
    (!want)[*5] |-> !integrating) else $error("still integrating");
  a_read_update: assert property (
    $fell(integrating) && pin && !sleep_req |-> ##[1:64] dac_update) else $error("no update");
  c_update: cover property (dac_update);
  c_read: cover property ($fell(integrating));
  c_sleep: cover property (sleep_req);
endmodule
bind pmi_integ_ctrl pmi_chk u_chk (.clk, .rst_n, .read_int_pin, .line_override, .int_enable, .sleep_req,
  .ctrl_wr, .ctrl_wdata, .ctrl_rdata, .power_result, .dac_code, .out_full_scale, .dac_update, .integrating);
`default_nettype wire

/* File: bench/pmi_host_model.sv */
// host line and converter feed model
`timescale 1ns/100ps
`default_nettype none
module pmi_host_model (
  // clock
  input wire logic clk,
  // bench request
  input wire logic integ_req,
  input wire logic [15:0] bus_val,
  input wire logic [15:0] sns_val,
  // device side
  input wire logic mux_selector,
  output logic read_int_pin,
  output logic sample_valid,
  output logic [15:0] sample_data
);
  logic [1:0] pace = 2'h0; // one sample per four cycles
  initial read_int_pin = 1'b0;
  initial sample_valid = 1'b0;
  initial sample_data = 16'h0;
  // line held low between periods, so long lows give hold updates
  always @(posedge clk) read_int_pin <= integ_req;
  // feed the channel the device expects; stale data is inverted
  always @(posedge clk) begin
    pace <= pace + 2'h1;
    sample_valid <= pace == 2'h3;
    sample_data <= (pace == 2'h3) ? (mux_selector ? sns_val : bus_val) : ~sample_data;
  end
endmodule
`default_nettype wire

/* File: bench/pmi_integ_ctrl_tb.sv */
// self-checking bench for the integration controller
`timescale 1ns/100ps
`default_nettype none
module pmi_integ_ctrl_tb;
  // bench-driven inputs
  logic clk = 1'b0, rst_n = 1'b0, integ_req = 1'b0, line_override = 1'b0, int_enable = 1'b0;
  logic sleep_req = 1'b0, ctrl_wr = 1'b0;
  logic [7:0] ctrl_wdata = 8'h00;
  logic [2:0] igain = 3'h0, vgain = 3'h0;
  logic [15:0] bus_val = 16'h0, sns_val = 16'h0, v, e;
  // design outputs
  logic read_int_pin, sample_valid, mux_selector, dac_update, integrating;
  logic [15:0] sample_data, power_result, sense_result, bus_result;
  logic [7:0] ctrl_rdata;
  logic [9:0] dac_code;
  logic [1:0] out_full_scale;
  int n_mismatch = 0, comparisons = 0, cycles = 0, n;
  // short hold keeps the run brief
  pmi_integ_ctrl #(.update_hold(100)) u_pmi_integ_ctrl (.clk, .rst_n, .read_int_pin, .line_override,
    .int_enable, .sleep_req, .ctrl_wr, .ctrl_wdata, .ctrl_rdata, .current_digital_gain(igain),
    .bus_digital_gain(vgain), .sample_valid, .sample_data, .mux_selector, .power_result, .sense_result,
    .bus_result, .dac_code, .out_full_scale, .dac_update, .integrating);
  pmi_host_model u_host (.clk, .integ_req, .bus_val, .sns_val, .mux_selector, .read_int_pin, .sample_valid,
    .sample_data);
  initial forever #2.5 clk = ~clk;
  // top ten result bits, saturating
  function automatic logic [15:0] exp_res(logic [47:0] x);
    return (x[47:32] != 16'h0) ? 16'hffc0 : {x[31:22], 6'h00};
  endfunction
  task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] d);
    ctrl_wdata <= d;
    ctrl_wr <= 1'b1;
    @(posedge clk);
    ctrl_wr <= 1'b0;
    @(posedge clk);
  endtask
  // bounded wait for the next update pulse
  task automatic wait_upd(int lim);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (dac_update !== 1'b1 && n < lim);
    cmp("update", 16'h1, 16'(n < lim));
  endtask
  task automatic count_upd(int k);
    n = 0;
    repeat (k) begin
      @(negedge clk);
      n += int'(dac_update === 1'b1);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // hang guard, tests need about 10k cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_mismatch++;
      final_report();
    end
  end
  initial begin
    void'($urandom(89));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    cmp("ctrl", 16'h0, ctrl_rdata);
    for (int i = 0; i < 4; i++) begin
      wr(8'(i << 6));
      cmp("range", 16'(i), out_full_scale);
    end
    $display("test registers done");
    // pin-controlled power, random operands
    bus_val <= 16'($urandom);
    sns_val <= 16'($urandom);
    igain <= 3'($urandom_range(0, 2));
    wr({2'($urandom), 6'h00});
    integ_req <= 1'b1;
    repeat (200) @(posedge clk);
    integ_req <= 1'b0;
    wait_upd(100);
    e = exp_res(({32'h0, bus_val} * sns_val) << igain);
    cmp("power", e, power_result);
    cmp("dac", e >> 6, dac_code);
    count_upd(300);
    cmp("hold updates", 16'h1, 16'(n));
    $display("test pin power done");
    // free-run sense, two periods
    v = 16'($urandom);
    bus_val <= v;
    sns_val <= v;
    wr({4'h1, 2'h0, 2'($urandom)});
    integ_req <= 1'b1;
    wait_upd(300);
    e = exp_res({16'h0, v, 16'h0} << igain);
    cmp("sense", e, sense_result);
    wait_upd(300);
    cmp("dac", e >> 6, dac_code);
    integ_req <= 1'b0;
    $display("test free sense done");
    // free-run bus at the sample cap
    vgain <= 3'($urandom);
    repeat (60) @(posedge clk);
    wr(8'h2c);
    integ_req <= 1'b1;
    wait_upd(9000);
    cmp("bus", exp_res({16'h0, v, 16'h0} << (vgain > 3'h5 ? 3'h5 : vgain)), bus_result);
    integ_req <= 1'b0;
    $display("test free bus done");
    // free-run power, two pairs per period
    repeat (60) @(posedge clk);
    wr(8'h31);
    integ_req <= 1'b1;
    wait_upd(300);
    cmp("free power", exp_res(({32'h0, v} * v) << igain), power_result);
    integ_req <= 1'b0;
    $display("test free power done");
    // partial free-run period is dropped
    repeat (60) @(posedge clk);
    wr(8'h3b);
    integ_req <= 1'b1;
    repeat (100) @(posedge clk);
    integ_req <= 1'b0;
    count_upd(200);
    cmp("discard", 16'h0, 16'(n));
    // override bit takes the line's place
    line_override <= 1'b1;
    int_enable <= 1'b1;
    repeat (6) @(posedge clk);
    cmp("override", 16'h1, integrating);
    int_enable <= 1'b0;
    repeat (6) @(posedge clk);
    line_override <= 1'b0;
    $display("test read entry done");
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
    repeat (2) @(posedge clk);
    cmp("sleep dac", 16'h0, dac_code);
    cmp("sleep bus", 16'h0, bus_result);
    $display("test sleep done");
    final_report();
  end
endmodule
`default_nettype wire
